// File: shared/hbg_params.svh
`ifndef HBG_PARAMS_SVH
`define HBG_PARAMS_SVH
// ==================================================
// register byte offsets
`define HBG_AW        8
`define HBG_OFF_CTRL  8'h00
`define HBG_OFF_TGT   8'h04
`define HBG_OFF_NORM  8'h08
`define HBG_OFF_STAT  8'h0C
// ==================================================
// control register fields
`define HBG_C_REQ     0
`define HBG_C_60HZ    1
`define HBG_C_UGRP    3:2
`define HBG_C_IGRP    5:4
`define HBG_C_ED      7:6
`define HBG_C_TGT     11:8
// target-tied settings used in the standards mode
`define HBG_T_PLL     3:0
`define HBG_T_MIN     9:4
`define HBG_T_MAX     15:10
// element-group settings used in normal mode
`define HBG_N_PLL1    3:0
`define HBG_N_PLL2    7:4
`define HBG_N_MIN     13:8
`define HBG_N_MAX     19:14
// status bits
`define HBG_S_MODE    0
`define HBG_S_REMOTE  1
`define HBG_S_REFUSED 2
`define HBG_S_NODATA  3
`define HBG_S_BUSY    4
// ==================================================
// reset values
`define HBG_RST_CTRL  32'h0000_0000
`define HBG_RST_TGT   32'h0000_C810
`define HBG_RST_NORM  32'h000C_8100
// ==================================================
// spectrum geometry and order limits
`define HBG_BINS_50HZ 4'hA
`define HBG_BINS_60HZ 4'hC
`define HBG_ORD_FUND  6'h01
`define HBG_ORD_LAST  6'h32
`define HBG_ORD_SAT   6'h3F
// measured target codes: elements 0..6, wiring sums 7..9
`define HBG_TGT_SUM0  4'h7
`define HBG_TGT_LAST  4'h9
// synchronised pins and feature disables
`define HBG_PIN_N     10
`define HBG_FUNC_N    6
`endif

// File: shared/hbg_pkg.sv
package hbg_pkg;
    // grouping selection per channel
    typedef enum logic [1:0] {
        GRP_NONE             = 2'h0,
        SUBGROUP_COMBINING   = 2'h1,
        FULL_GROUP_COMBINING = 2'h2
    } hbg_grouping_type;
    // governing standard edition
    typedef enum logic [1:0] {
        ED_1_0    = 2'h0,
        ED_2_0    = 2'h1,
        ED_2_0_A1 = 2'h2
    } hbg_edition_type;
    // root engine states, gray along the path
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_RUN  = 2'b01,
        SQ_DONE = 2'b11
    } hbg_sq_state_type;
endpackage

// File: shared/hbg_sqrt_if.sv
// ==================================================
// request and answer of the square root engine
interface hbg_sqrt_if #(parameter int ACC_W = 38);
    logic                 start;
    logic [ACC_W-1:0]     radicand;
    logic                 busy;
    logic                 done;
    logic [ACC_W/2-1:0]   root;
    modport client (output start, radicand, input busy, done, root);
    modport server (input start, radicand, output busy, done, root);
endinterface

// File: hw/hbg_sqrt.sv
// ==================================================
// iterative integer square root, one result bit per cycle
module hbg_sqrt #(
    parameter int ACC_W = 38
) (
    input wire logic     pclk,
    input wire logic     presetn,
    hbg_sqrt_if.server   sq
);
    import hbg_pkg::*;
    localparam int RW = ACC_W / 2;
    localparam logic [ACC_W-1:0] ONE_INIT = {2'b01, {(ACC_W-2){1'b0}}};

    if (ACC_W % 2 != 0 || ACC_W < 4) begin : g_chk
        $error("hbg_sqrt: ACC_W must be even and at least 4");
    end

    hbg_sq_state_type state;
    logic [ACC_W-1:0] op;
    logic [ACC_W-1:0] res;
    logic [ACC_W-1:0] one;
    logic [ACC_W-1:0] trial;
    logic             fits;

    // one restoring step
    assign trial = res + one;
    assign fits  = (op >= trial);

    // sequencing and datapath
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= SQ_IDLE;
            op      <= '0;
            res     <= '0;
            one     <= '0;
            sq.root <= '0;
            sq.done <= 1'b0;
            sq.busy <= 1'b0;
        end else begin
            sq.done <= 1'b0;
            case (state)
                SQ_IDLE: begin
                    if (sq.start) begin
                        op      <= sq.radicand;
                        res     <= '0;
                        one     <= ONE_INIT;
                        sq.busy <= 1'b1;
                        state   <= SQ_RUN;
                    end
                end
                SQ_RUN: begin
                    op  <= fits ? op - trial : op;
                    res <= fits ? (res >> 1) + one : res >> 1;
                    one <= one >> 2;
                    if (one == {{(ACC_W-1){1'b0}}, 1'b1}) begin
                        state <= SQ_DONE;
                    end
                end
                SQ_DONE: begin
                    sq.root <= res[RW-1:0];
                    sq.done <= 1'b1;
                    sq.busy <= 1'b0;
                    state   <= SQ_IDLE;
                end
                default: state <= SQ_IDLE;
            endcase
        end
    end
endmodule

// File: hw/hbg_top.sv
`include "hbg_params.svh"
module hbg_top #(
    parameter int BIN_W = 32,
    parameter int ACC_W = 38
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`HBG_AW-1:0]     paddr,
    input wire logic [31:0]            pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input wire logic                   sync_slave,
    input wire logic                   integ_busy,
    input wire logic                   store_running,
    input wire logic                   media_busy,
    input wire logic                   remote_app,
    input wire logic [1:0]             panel_in,
    input wire logic [2:0]             sum_assigned,
    output logic [1:0]                 panel_out,
    output logic [`HBG_FUNC_N-1:0]     func_off,
    output logic [3:0]                 pll_sel,
    output hbg_pkg::hbg_edition_type   edition,
    input wire logic                   bin_valid,
    input wire logic                   bin_first,
    input wire logic                   bin_chan,
    input wire logic [BIN_W-1:0]       bin_sq,
    output logic                       bin_ready,
    output logic                       res_valid,
    output logic [5:0]                 res_order,
    output logic                       res_chan,
    output logic                       res_report,
    output logic                       res_thd,
    output logic [ACC_W/2-1:0]         res_value
);
    import hbg_pkg::*;

    if (ACC_W < BIN_W + 4 || ACC_W % 2 != 0) begin : g_chk
        $error("hbg_top: ACC_W must be even and hold thirteen squared bins");
    end

    // ==================================================
    // pin synchronisers
    logic [`HBG_PIN_N-1:0] pin_raw, s1, s2, s3, pin_f;
    logic       remote_f, blocked;
    logic [1:0] panel_f;
    logic [2:0] sum_f;
    assign pin_raw = {sum_assigned, panel_in, media_busy, store_running,
                      integ_busy, sync_slave, remote_app};

    // three stages; a level counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            pin_f <= '0;
        end else begin
            s1    <= pin_raw;
            s2    <= s1;
            s3    <= s2;
            pin_f <= (s2 & s3) | (pin_f & (s2 | s3));
        end
    end
    assign remote_f = pin_f[0];
    assign blocked  = |pin_f[4:1];
    assign panel_f  = pin_f[6:5];
    assign sum_f    = pin_f[9:7];

    // ==================================================
    // registers and APB slave
    logic [31:0] ctrl, tgt, norm;
    logic        in_mode, refused, no_data;
    logic        setup, wr_en, addr_ok;
    logic [31:0] rd_word;
    hbg_sqrt_if #(.ACC_W(ACC_W)) sq ();

    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pready & pwrite;
    assign addr_ok = (paddr == `HBG_OFF_CTRL) || (paddr == `HBG_OFF_TGT) ||
                     (paddr == `HBG_OFF_NORM) || (paddr == `HBG_OFF_STAT);

    // read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            `HBG_OFF_CTRL: rd_word = ctrl;
            `HBG_OFF_TGT:  rd_word = tgt;
            `HBG_OFF_NORM: rd_word = norm;
            `HBG_OFF_STAT: begin
                rd_word[`HBG_S_MODE]    = in_mode;
                rd_word[`HBG_S_REMOTE]  = remote_f;
                rd_word[`HBG_S_REFUSED] = refused;
                rd_word[`HBG_S_NODATA]  = no_data;
                rd_word[`HBG_S_BUSY]    = sq.busy;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // one wait-free access phase: answer registered at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~addr_ok;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // writable settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `HBG_RST_CTRL;
            tgt  <= `HBG_RST_TGT;
            norm <= `HBG_RST_NORM;
        end else if (wr_en) begin
            case (paddr)
                `HBG_OFF_CTRL: ctrl <= pwdata;
                `HBG_OFF_TGT:  tgt  <= pwdata;
                `HBG_OFF_NORM: norm <= pwdata;
                default: ;
            endcase
        end
    end

    // ==================================================
    // mode control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_mode <= 1'b0;
        end else if (remote_f) begin
            in_mode <= 1'b1;
        end else if (!ctrl[`HBG_C_REQ]) begin
            in_mode <= 1'b0;
        end else if (!in_mode && !blocked) begin
            in_mode <= 1'b1;
        end
    end

    // sticky refusal flag, write one to clear; a new refusal wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused <= 1'b0;
        end else if (ctrl[`HBG_C_REQ] && !in_mode && blocked && !remote_f) begin
            refused <= 1'b1;
        end else if (wr_en && paddr == `HBG_OFF_STAT && pwdata[`HBG_S_REFUSED]) begin
            refused <= 1'b0;
        end
    end

    // empty wiring sum or unknown target code gives no data
    logic [3:0] sum_idx;
    assign sum_idx = ctrl[`HBG_C_TGT] - `HBG_TGT_SUM0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            no_data <= 1'b0;
        end else begin
            no_data <= (ctrl[`HBG_C_TGT] >= `HBG_TGT_SUM0) &&
                       ((ctrl[`HBG_C_TGT] > `HBG_TGT_LAST) ||
                        !sum_f[sum_idx[1:0]]);
        end
    end

    // side outputs: panel gate, feature disables, pll, edition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            panel_out <= 2'h0;
            func_off  <= '0;
            pll_sel   <= 4'h0;
            edition   <= ED_1_0;
        end else begin
            panel_out <= remote_f ? 2'h0 : panel_f;
            func_off  <= {`HBG_FUNC_N{in_mode}};
            pll_sel   <= in_mode ? tgt[`HBG_T_PLL] : norm[`HBG_N_PLL1];
            edition   <= hbg_edition_type'(ctrl[`HBG_C_ED]);
        end
    end

    // ==================================================
    // bin walk and accumulation
    logic [3:0]       pos, cur_pos, period, half, last;
    logic [5:0]       ord, cur_ord, lo, hi;
    logic [ACC_W-1:0] sub_acc, grp_acc, bin_x, half_x, sub_sum, grp_sum, rad;
    logic             take, ev_h, ev_s, ev_g, fund, in_rng, rep, thd, emit;
    hbg_grouping_type gsel;

    assign take    = bin_valid & bin_ready;
    assign cur_pos = bin_first ? 4'h0 : pos;
    assign cur_ord = bin_first ? 6'h00 : ord;
    assign period  = ctrl[`HBG_C_60HZ] ? `HBG_BINS_60HZ : `HBG_BINS_50HZ;
    assign half    = period >> 1;
    assign last    = period - 4'h1;
    assign bin_x   = ACC_W'(bin_sq);
    assign half_x  = bin_x >> 1;
    assign sub_sum = sub_acc + bin_x;
    assign grp_sum = grp_acc + half_x;

    // position inside the order spacing and order count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos <= 4'h0;
            ord <= 6'h00;
        end else if (take) begin
            if (cur_pos == last) begin
                pos <= 4'h0;
                ord <= (cur_ord == `HBG_ORD_SAT) ? cur_ord : cur_ord + 6'h01;
            end else begin
                pos <= cur_pos + 4'h1;
                ord <= cur_ord;
            end
        end
    end

    // wide square sums; roots only after a sum closes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_acc <= '0;
            grp_acc <= '0;
        end else if (take) begin
            sub_acc <= (cur_pos == last) ? bin_x : sub_sum;
            if (cur_pos == half) begin
                grp_acc <= half_x;
            end else begin
                grp_acc <= bin_first ? bin_x : grp_acc + bin_x;
            end
        end
    end

    // selection per channel; grouping only applies in the mode
    assign gsel = !in_mode ? GRP_NONE :
                  hbg_grouping_type'(bin_chan ? ctrl[`HBG_C_IGRP] : ctrl[`HBG_C_UGRP]);
    assign lo     = in_mode ? tgt[`HBG_T_MIN] : norm[`HBG_N_MIN];
    assign hi     = in_mode ? tgt[`HBG_T_MAX] : norm[`HBG_N_MAX];
    assign ev_h   = take && cur_pos == 4'h0;
    assign ev_s   = take && cur_pos == 4'h1;
    assign ev_g   = take && cur_pos == half;
    assign fund   = cur_ord == `HBG_ORD_FUND;
    assign in_rng = cur_ord >= lo && cur_ord <= hi &&
                    cur_ord >= `HBG_ORD_FUND && cur_ord <= `HBG_ORD_LAST;
    assign rep = in_rng && ((ev_h && (fund || gsel == GRP_NONE)) ||
                 (ev_s && !fund && gsel == SUBGROUP_COMBINING) ||
                 (ev_g && !fund && gsel == FULL_GROUP_COMBINING));
    assign thd = in_mode && fund && ((ev_h && gsel == GRP_NONE) ||
                 (ev_s && gsel == SUBGROUP_COMBINING) ||
                 (ev_g && gsel == FULL_GROUP_COMBINING));
    assign emit = (rep || thd) && !(in_mode && no_data);
    assign rad  = ev_s ? sub_sum : (ev_g ? grp_sum : bin_x);

    // ==================================================
    // root request, stall and result
    logic [5:0] tag_ord;
    logic       tag_chan, tag_rep, tag_thd;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sq.start    <= 1'b0;
            sq.radicand <= '0;
            tag_ord     <= 6'h00;
            tag_chan    <= 1'b0;
            tag_rep     <= 1'b0;
            tag_thd     <= 1'b0;
        end else begin
            sq.start <= emit;
            if (emit) begin
                sq.radicand <= rad;
                tag_ord     <= cur_ord;
                tag_chan    <= bin_chan;
                tag_rep     <= rep;
                tag_thd     <= thd;
            end
        end
    end

    // upstream stalls while a root is in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bin_ready <= 1'b1;
        end else if (emit) begin
            bin_ready <= 1'b0;
        end else if (sq.done) begin
            bin_ready <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid  <= 1'b0;
            res_order  <= 6'h00;
            res_chan   <= 1'b0;
            res_report <= 1'b0;
            res_thd    <= 1'b0;
            res_value  <= '0;
        end else begin
            res_valid <= sq.done;
            if (sq.done) begin
                res_order  <= tag_ord;
                res_chan   <= tag_chan;
                res_report <= tag_rep;
                res_thd    <= tag_thd;
                res_value  <= sq.root;
            end
        end
    end

    hbg_sqrt #(.ACC_W(ACC_W)) u_root (
        .pclk    (pclk),
        .presetn (presetn),
        .sq      (sq)
    );

    // ==================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_entry_refused: assert property (
        !in_mode && blocked && !remote_f |=> !in_mode)
        else $error("mode entered while blocked");
    a_remote_forces: assert property (
        remote_f |=> in_mode)
        else $error("remote control did not force the mode");
    a_panel_ignored: assert property (
        remote_f |=> panel_out == 2'h0)
        else $error("panel input passed under remote");
    a_features_off: assert property (
        in_mode |=> &func_off)
        else $error("features not disabled in mode");
    a_pll_target: assert property (
        in_mode |=> pll_sel == $past(tgt[`HBG_T_PLL]))
        else $error("pll source not from target");
    a_spacing_50: assert property (
        take && !bin_first && pos == `HBG_BINS_50HZ - 4'h1 && !ctrl[`HBG_C_60HZ] |=> pos == 4'h0)
        else $error("50 Hz spacing wrong");
    a_spacing_60: assert property (
        take && !bin_first && pos == `HBG_BINS_60HZ - 4'h1 && ctrl[`HBG_C_60HZ] |=> pos == 4'h0)
        else $error("60 Hz spacing wrong");
    a_root_stall: assert property (
        sq.start |-> !bin_ready [*2] ##[1:40] bin_ready)
        else $error("stall around root wrong");
    a_fund_plain: assert property (
        emit && ev_h && fund && in_rng |=> tag_rep && sq.radicand == ACC_W'($past(bin_sq)))
        else $error("fundamental not plain bin");

    c_mode_entry: cover property ($rose(in_mode) && !remote_f);
    c_thd_only:   cover property (res_valid && res_thd && !res_report);
    c_group_rep:  cover property (emit && ev_g && rep);
    c_refusal:    cover property ($rose(refused));
endmodule

// File: bench/hbg_bin_src.sv
// ==================================================
// upstream spectrum source: squared bins, ascending from bin 0
module hbg_bin_src #(
    parameter int BIN_W = 32
) (
    input wire logic          pclk,
    input wire logic          bin_ready,
    output logic              bin_valid,
    output logic              bin_first,
    output logic              bin_chan,
    output logic [BIN_W-1:0]  bin_sq
);
    timeunit 1ns;
    timeprecision 1ps;
    import hbg_pkg::*;

    // idle levels at time zero
    initial begin
        bin_valid = 1'b0;
        bin_first = 1'b0;
        bin_chan = 1'b0;
        bin_sq = '0;
    end

    // one frame of n bins; harmonic bins four times the rest
    // slow frames drop valid and scramble data on odd bins
    task automatic frame(input logic ch, input int p, input int n, input bit slow);
        @(posedge pclk);
        for (int b = 0; b < n; b++) begin
            if (slow && b[0]) begin
                bin_valid <= 1'b0;
                bin_sq <= ~bin_sq;
                @(posedge pclk);
            end
            bin_valid <= 1'b1;
            bin_first <= (b == 0);
            bin_chan <= ch;
            bin_sq <= BIN_W'((b % p == 0) ? 64 : 16);
            do @(posedge pclk); while (bin_ready !== 1'b1);
        end
        bin_valid <= 1'b0;
        bin_sq <= ~bin_sq;
    endtask
endmodule

// File: bench/harmonic_bin_grouping_test.sv
`include "hbg_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module harmonic_bin_grouping_test;
    timeunit 1ns;
    timeprecision 1ps;
    import hbg_pkg::*;
    // ==================================================
    // signals
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic              pwrite = 0, remote_app = 0, lerr;
    logic [7:0]        paddr = 0;
    logic [31:0]       pwdata = 0, prdata, q, bin_sq;
    logic              pready, pslverr, bin_valid, bin_first, bin_chan, bin_ready;
    logic              res_valid, res_chan, res_report, res_thd;
    logic [3:0]        blk = 0, pll_sel;
    logic [1:0]        panel_in = 0, panel_out;
    logic [2:0]        sum_assigned = 0;
    logic [5:0]        func_off, res_order;
    logic [18:0]       res_value, v1, v2, vt;
    hbg_edition_type   edition;
    int                bad_count = 0, n_tests = 0;

    // 25 MHz clock
    always #20 pclk = ~pclk;

    hbg_top i_hbg_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sync_slave(blk[0]), .integ_busy(blk[1]),
        .store_running(blk[2]), .media_busy(blk[3]), .remote_app, .panel_in,
        .sum_assigned, .panel_out, .func_off, .pll_sel, .edition, .bin_valid,
        .bin_first, .bin_chan, .bin_sq, .bin_ready, .res_valid, .res_order,
        .res_chan, .res_report, .res_thd, .res_value);
    hbg_bin_src i_hbg_bin_src (.pclk, .bin_ready, .bin_valid, .bin_first,
        .bin_chan, .bin_sq);

    // catch fundamental and second order results
    always @(posedge pclk) begin
        if (res_valid === 1'b1 && res_order === 6'h01 && res_report === 1'b1) v1 <= res_value;
        if (res_valid === 1'b1 && res_order === 6'h01 && res_thd === 1'b1) vt <= res_value;
        if (res_valid === 1'b1 && res_order === 6'h02 && res_report === 1'b1) v2 <= res_value;
    end

    // ==================================================
    // tasks
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one apb transfer; data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // masked register read against an expected word
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("reg", e, q & m)
    endtask

    // expected order value for grouping g and spacing p
    function automatic logic [18:0] ev(input int g, input int p);
        return (g == 0) ? 19'h8 : (g == 1) ? 19'h9 : (p == 10) ? 19'hE : 19'hF;
    endfunction

    // one frame; the fundamental report is always the plain bin
    task automatic run(input logic ch, input int p, input logic [18:0] e, input bit m);
        v1 = 'x;
        v2 = 'x;
        vt = 'x;
        i_hbg_bin_src.frame(ch, p, 3 * p, ch);
        repeat (25) @(posedge pclk);
        `CHK("order2", e, v2)
        `CHK("fund", 19'h8, v1)
        if (m) `CHK("thd", e, vt)
        `CHK("chan", ch, res_chan)
    endtask

    // ==================================================
    // main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`HBG_OFF_CTRL, '1, `HBG_RST_CTRL);
        rdc(`HBG_OFF_TGT, '1, `HBG_RST_TGT);
        rdc(`HBG_OFF_NORM, '1, `HBG_RST_NORM);
        apb(1'b0, 8'h10, 32'h0);
        `CHK("slverr", 1'b1, lerr)
        apb(1'b1, `HBG_OFF_NORM, 32'h000C_8103);
        apb(1'b1, `HBG_OFF_TGT, 32'h0000_C815);
        apb(1'b1, `HBG_OFF_CTRL, 32'h8);
        run(1'b0, 10, 19'h8, 0);
        `CHK("pll", 4'h3, pll_sel)
        for (int k = 0; k < 4; k++) begin
            blk <= 4'h1 << k;
            repeat (8) @(posedge pclk);
            apb(1'b1, `HBG_OFF_CTRL, 32'h1);
            rdc(`HBG_OFF_STAT, 32'h7, 32'h4);
            apb(1'b1, `HBG_OFF_STAT, 32'h4);
        end
        blk <= 4'h0;
        repeat (8) @(posedge pclk);
        apb(1'b1, `HBG_OFF_STAT, 32'h4);
        rdc(`HBG_OFF_STAT, 32'h7, 32'h1);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `HBG_OFF_CTRL, 32'(1 | (i / 3) << 1 | (i % 3) << 2 | (2 - i % 3) << 4
                | (i % 3) << 6));
            repeat (3) @(negedge pclk);
            `CHK("func_off", 6'h3F, func_off)
            `CHK("pll", 4'h5, pll_sel)
            `CHK("edition", hbg_edition_type'(i % 3), edition)
            run(1'b0, (i / 3) ? 12 : 10, ev(i % 3, (i / 3) ? 12 : 10), 1);
            run(1'b1, (i / 3) ? 12 : 10, ev(2 - i % 3, (i / 3) ? 12 : 10), 1);
        end
        apb(1'b1, `HBG_OFF_CTRL, 32'h701);
        rdc(`HBG_OFF_STAT, 32'h8, 32'h8);
        sum_assigned <= 3'h1;
        repeat (8) @(posedge pclk);
        rdc(`HBG_OFF_STAT, 32'h8, 32'h0);
        apb(1'b1, `HBG_OFF_CTRL, 32'h0);
        remote_app <= 1'b1;
        panel_in <= 2'h3;
        repeat (8) @(negedge pclk);
        rdc(`HBG_OFF_STAT, 32'h3, 32'h3);
        `CHK("panel", 2'h0, panel_out)
        remote_app <= 1'b0;
        repeat (8) @(negedge pclk);
        `CHK("panel", 2'h3, panel_out)
        `CHK("func_off", 6'h00, func_off)
        wrap_up();
    end

    // watchdog well past the expected run length
    initial begin
        #(40 * 20000);
        bad_count++;
        wrap_up();
    end
endmodule
